// ---- psw_pkg.sv ----
package psw_pkg;
	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned T_STEP_MS     = 4;
	localparam int unsigned T_CAN5_MS     = 20;
	localparam int unsigned T_WAKE_MS     = 20;
	localparam int unsigned STEP_CYC      = T_STEP_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned CAN5_CYC      = T_CAN5_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned WAKE_CYC      = T_WAKE_MS * 1000000 / CLK_PERIOD_NS;

	// Register byte offsets
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CONFIG = 8'h08;
	localparam logic [7:0] OFS_TIMING = 8'h0c;
	localparam logic [7:0] OFS_WAKMSG = 8'h10;

	// Command word fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_ARG_LSB  = 4;
	localparam int CMD_FORM_LSB = 12;

	// Config fields
	localparam int CFG_MEM_BIT   = 0;
	localparam int CFG_ADAPT_BIT = 1;
	localparam int CFG_CAN_TIMER_TIMES_FIVE_BIT  = 2;
	localparam int CFG_EXTA_BIT  = 3;
	localparam int CFG_TDEF_LSB  = 8;

	// Reset values
	localparam logic [7:0]  TMO_DEFAULT   = 8'h20;
	localparam logic [7:0]  WAKE_DEFAULT  = 8'h92;
	localparam logic [7:0]  TMO_SEARCH_MIN = 8'h19;
	localparam logic [31:0] WAKMSG_RESET  = 32'h68_6a_f1_01;

	// Protocol codes
	localparam logic [3:0] PR_AUTO  = 4'h0;
	localparam logic [3:0] PR_FIRST = 4'h1;
	localparam logic [3:0] PR_SLOW_A = 4'h3;
	localparam logic [3:0] PR_SLOW_B = 4'h4;
	localparam logic [3:0] PR_FAST_K = 4'h5;
	localparam logic [3:0] PR_CAN_LO = 4'h6;
	localparam logic [3:0] PR_HDCAN  = 4'ha;
	localparam logic [3:0] PR_LAST  = 4'hc;
	localparam logic [3:0] PR_COUNT = 4'hc;

	typedef enum logic [3:0] {
		OP_NONE      = 4'h0,
		OP_SETPROTO  = 4'h1,
		OP_TIMEOUT   = 4'h2,
		OP_WAKEUP    = 4'h3,
		OP_RXADDR    = 4'h4,
		OP_AUTORX    = 4'h5,
		OP_SLOWINIT  = 4'h6,
		OP_STDSEQ    = 4'h7,
		OP_CLOSE     = 4'h8
	} psw_op_e;

	typedef enum logic [1:0] {
		SPF_PLAIN  = 2'h0,
		SPF_ZERO2  = 2'h1,
		SPF_AUTO_A = 2'h2,
		SPF_A_AUTO = 2'h3
	} psw_spform_e;

	typedef enum logic [1:0] {
		SR_IDLE = 2'h0,
		SR_INIT = 2'h1,
		SR_WAIT = 2'h2,
		SR_CONN = 2'h3
	} psw_srch_e;
endpackage

// ---- psw_tick_timer.sv ----
`timescale 1ns/1ns
// Counts a number of units, each a runtime-selected number of cycles
module psw_tick_timer #(
	parameter int CYC_W = 24
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             start,
	input  wire logic             halt,
	input  wire logic [CYC_W-1:0] unit_cyc,
	input  wire logic [7:0]       units,
	output logic                  expired,
	output logic                  running
);
	logic [CYC_W-1:0] pre_q;
	logic [7:0]       cnt_q;

	// Start reloads, halt wins over counting; zero units never starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q   <= '0;
			cnt_q   <= 8'h00;
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (start && units != 8'h00) begin
				pre_q   <= unit_cyc - CYC_W'(1);
				cnt_q   <= units;
				running <= 1'b1;
			end else if (halt) begin
				running <= 1'b0;
			end else if (running) begin
				if (pre_q != '0) begin
					pre_q <= pre_q - CYC_W'(1);
				end else if (cnt_q == 8'h01) begin
					running <= 1'b0;
					expired <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 8'h01;
					pre_q <= unit_cyc - CYC_W'(1);
				end
			end
		end
	end
endmodule

// ---- psw_protocol_ctrl.sv ----
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
//Contract
//[RULE1] Slow initiation command runs only with protocol 3 or 4, else error.
//[RULE2] Initiation runs before first message; separate command initiates only.
//[RULE3] Nonzero set-protocol selects it and writes default, memory setting ignored.
//[RULE4] Protocol codes 0 to C decoded; 0 automatic, 6 up are CAN.
//[RULE5] Automatic search tries until success; memory on stores found protocol.
//[RULE6] Single zero, A0 and 0A forms select automatic without store write.
//[RULE7] Only the double-zero form writes zero to the stored default.
//[RULE8] Fixed protocol alone is tried; failure reports bus-initiation error.
//[RULE9] Auto-with-start tries given protocol first, always saves, A either side.
//[RULE10] Receive address command filters responses until automatic addressing returns.
//[RULE11] Filter compares one byte; ignored for heavy-duty CAN and extended addressing.
//[RULE12] Fast search order by default; standard sequence makes it ascending.
//[RULE13] Response timeout reports no data; adaptive also times further responses.
//[RULE14] Timeout steps 4 ms, or 20 ms on CAN with times-five.
//[RULE15] With adaptive timing the programmed timeout is an upper limit.
//[RULE16] Timeout default is 32, taken from a programmable parameter. The code resets it to TMO_DEFAULT, which is 8'h20.
//[RULE17] Timeout argument zero restores the default.
//[RULE18] Searches enforce an internal minimum timeout; longer ones honoured.
//[RULE19] Protocols 3, 4, 5 send periodic wakeups when connected; replies discarded.
//[RULE20] Wakeup interval is argument times 20 ms; default 92.
//[RULE21] Interval zero stops wakeups until protocol closed and reinitialized.
//[RULE22] Wakeup message gets a checksum and goes out at the interval.
//[RULE23] Out-of-range protocol or command gives error, settings unchanged.
module psw_protocol_ctrl #(
	parameter int unsigned STEP_CYCLES = psw_pkg::STEP_CYC,
	parameter int unsigned CAN5_CYCLES = psw_pkg::CAN5_CYC,
	parameter int unsigned WAKE_CYCLES = psw_pkg::WAKE_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        msg_req,
	input  wire logic        init_ok,
	input  wire logic        init_fail,
	input  wire logic        req_sent,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_addr,
	input  wire logic [7:0]  adapt_est,
	output logic             init_req,
	output logic      [3:0]  try_proto,
	output logic             msg_go,
	output logic             wake_req,
	output logic      [7:0]  wake_csum,
	output logic             no_data,
	output logic             bus_err,
	output logic             nv_wr,
	output logic      [4:0]  nv_data,
	output logic             rx_accept
);
	localparam int CYC_W = 24;

	if (STEP_CYCLES == 0 || CAN5_CYCLES == 0 || WAKE_CYCLES == 0 ||
		CAN5_CYCLES >= (1 << CYC_W) || WAKE_CYCLES >= (1 << CYC_W) || STEP_CYCLES >= (1 << CYC_W)) begin : g_chk
		$error("psw_protocol_ctrl: cycle counts out of range");
	end

	// Fast search order: CAN 6, 8, 7, 9 first, then the slower legacy buses 1 to 5, then CAN A to C
	function automatic logic [3:0] next_proto(input logic [3:0] p, input logic std);
		logic [3:0] r;
		r = psw_pkg::PR_FIRST;
		if (std) begin
			r = (p >= psw_pkg::PR_LAST) ? psw_pkg::PR_FIRST : p + 4'h1; // RULE12
		end else begin
			unique case (p)
				4'h6: r = 4'h8;
				4'h8: r = 4'h7;
				4'h7: r = 4'h9;
				4'h9: r = 4'h1;
				4'h5: r = 4'ha;
				4'hc: r = 4'h6;
				default: r = p + 4'h1;
			endcase
		end
		return r;
	endfunction

	function automatic logic is_can(input logic [3:0] p);
		return p >= psw_pkg::PR_CAN_LO && p <= psw_pkg::PR_LAST; // RULE4
	endfunction

	// Bus-side signals and registers
	logic        wr_stb;
	logic        cmd_stb;
	logic [31:0] cfg_q;
	logic [31:0] wakmsg_q;
	logic [3:0]  sel_q;
	logic        auto_q;
	logic [3:0]  nvdef_q;
	logic        std_q;
	logic        cmd_err_q;
	logic [7:0]  tmo_q;
	logic [7:0]  wake_arg_q;
	logic        wake_stop_q;
	logic [7:0]  rxa_q;
	logic        rxa_on_q;
	logic        bus_err_q;
	logic        nodata_seen_q;
	logic [3:0]  op;
	logic [7:0]  arg;
	logic [1:0]  form;
	logic        a_valid;
	psw_pkg::psw_srch_e st_q;
	logic [3:0]  cur_q;
	logic [3:0]  tries_q;
	logic        msg_pend_q;
	logic        got_resp_q;
	logic        wake_quiet_q;
	logic        tmo_exp;
	logic        tmo_run;
	logic        wake_exp;
	logic        wake_run;
	logic        wake_ok;
	logic [7:0]  tmo_eff;
	logic [23:0] tmo_unit;

	assign wr_stb  = psel && penable && pready && pwrite;
	assign cmd_stb = wr_stb && paddr == psw_pkg::OFS_CMD;
	assign op      = pwdata[psw_pkg::CMD_OP_LSB +: 4];
	assign arg     = pwdata[psw_pkg::CMD_ARG_LSB +: 8];
	assign form    = pwdata[psw_pkg::CMD_FORM_LSB +: 2];
	assign a_valid = arg[3:0] <= psw_pkg::PR_LAST && arg[7:4] == 4'h0; // RULE23

	// APB slave: one wait-free access, answer prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable && !pready;
			pslverr <= psel && !penable && !pready && !(paddr inside {psw_pkg::OFS_CMD,
				psw_pkg::OFS_STATUS, psw_pkg::OFS_CONFIG, psw_pkg::OFS_TIMING, psw_pkg::OFS_WAKMSG});
			unique case (paddr)
				psw_pkg::OFS_STATUS: prdata <= {16'h0000, bus_err_q, nodata_seen_q, rxa_on_q, std_q,
					nvdef_q, 1'b0, cmd_err_q, st_q == psw_pkg::SR_CONN, auto_q, cur_q};
				psw_pkg::OFS_CONFIG: prdata <= cfg_q;
				psw_pkg::OFS_TIMING: prdata <= {wake_stop_q, 7'h00, rxa_q, wake_arg_q, tmo_q};
				psw_pkg::OFS_WAKMSG: prdata <= wakmsg_q;
				default:             prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Config and wakeup message bytes; default timeout lives in config
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q    <= {16'h0000, psw_pkg::TMO_DEFAULT, 8'h00}; // RULE16
			wakmsg_q <= psw_pkg::WAKMSG_RESET;
		end else if (wr_stb && paddr == psw_pkg::OFS_CONFIG) begin
			cfg_q <= {16'h0000, pwdata[15:8], 4'h0, pwdata[3:0]};
		end else if (wr_stb && paddr == psw_pkg::OFS_WAKMSG) begin
			wakmsg_q <= pwdata;
		end
	end

	// Protocol selection and nonvolatile default
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q     <= psw_pkg::PR_AUTO;
			auto_q    <= 1'b1;
			nvdef_q   <= psw_pkg::PR_AUTO;
			nv_wr     <= 1'b0;
			nv_data   <= 5'h00;
			std_q     <= 1'b0;
			cmd_err_q <= 1'b0;
		end else begin
			nv_wr <= 1'b0;
			if (cmd_stb) begin
				cmd_err_q <= 1'b0;
				unique case (op)
					psw_pkg::OP_SETPROTO: begin
						if (!a_valid) begin
							cmd_err_q <= 1'b1; // RULE23
						end else if (form == psw_pkg::SPF_ZERO2) begin
							sel_q   <= psw_pkg::PR_AUTO; // RULE7
							auto_q  <= 1'b1;
							nvdef_q <= psw_pkg::PR_AUTO;
							nv_wr   <= 1'b1;
							nv_data <= {1'b1, psw_pkg::PR_AUTO};
						end else if (arg[3:0] == psw_pkg::PR_AUTO) begin
							sel_q  <= psw_pkg::PR_AUTO; // RULE6
							auto_q <= 1'b1;
						end else begin
							// Auto forms keep searching; plain form fixes the protocol
							sel_q   <= arg[3:0]; // RULE3 RULE9
							auto_q  <= form != psw_pkg::SPF_PLAIN;
							nvdef_q <= arg[3:0];
							nv_wr   <= 1'b1;
							nv_data <= {form != psw_pkg::SPF_PLAIN, arg[3:0]};
						end
					end
					psw_pkg::OP_STDSEQ: std_q <= 1'b1; // RULE12
					psw_pkg::OP_SLOWINIT: cmd_err_q <= !(sel_q == psw_pkg::PR_SLOW_A ||
						sel_q == psw_pkg::PR_SLOW_B); // RULE1
					psw_pkg::OP_TIMEOUT, psw_pkg::OP_WAKEUP, psw_pkg::OP_RXADDR,
					psw_pkg::OP_AUTORX, psw_pkg::OP_CLOSE: cmd_err_q <= 1'b0;
					default: cmd_err_q <= 1'b1; // RULE23
				endcase
			end else if (st_q == psw_pkg::SR_WAIT && init_ok && auto_q && cfg_q[psw_pkg::CFG_MEM_BIT]) begin
				nvdef_q <= cur_q; // RULE5
				nv_wr   <= 1'b1;
				nv_data <= {1'b1, cur_q};
			end
		end
	end

	// Timeout, wakeup interval and receive address settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmo_q       <= psw_pkg::TMO_DEFAULT;
			wake_arg_q  <= psw_pkg::WAKE_DEFAULT; // RULE20
			wake_stop_q <= 1'b0;
			rxa_q       <= 8'h00;
			rxa_on_q    <= 1'b0;
		end else begin
			if (cmd_stb && op == psw_pkg::OP_TIMEOUT) begin
				tmo_q <= (arg == 8'h00) ? cfg_q[psw_pkg::CFG_TDEF_LSB +: 8] : arg; // RULE17
			end
			// Zero stops the messages but keeps the stored interval
			if (cmd_stb && op == psw_pkg::OP_WAKEUP) begin
				if (arg == 8'h00) begin
					wake_stop_q <= 1'b1; // RULE21
				end else begin
					wake_arg_q <= arg;
				end
			end else if (st_q == psw_pkg::SR_CONN && (cmd_stb && op == psw_pkg::OP_CLOSE)) begin
				wake_stop_q <= 1'b0; // RULE21
			end
			if (cmd_stb && op == psw_pkg::OP_RXADDR) begin
				rxa_q    <= arg; // RULE10
				rxa_on_q <= 1'b1;
			end else if (cmd_stb && op == psw_pkg::OP_AUTORX) begin
				rxa_on_q <= 1'b0; // RULE10
			end
		end
	end

	// Search and connection state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q       <= psw_pkg::SR_IDLE;
			cur_q      <= psw_pkg::PR_AUTO;
			tries_q    <= 4'h0;
			msg_pend_q <= 1'b0;
			init_req   <= 1'b0;
			try_proto  <= 4'h0;
			msg_go     <= 1'b0;
			bus_err    <= 1'b0;
			bus_err_q  <= 1'b0;
		end else begin
			init_req <= 1'b0;
			msg_go   <= 1'b0;
			bus_err  <= 1'b0;
			unique case (st_q)
				psw_pkg::SR_IDLE: begin
					if (msg_req || (cmd_stb && op == psw_pkg::OP_SLOWINIT && (sel_q == psw_pkg::PR_SLOW_A ||
						sel_q == psw_pkg::PR_SLOW_B))) begin
						// Slow-init command connects without a message
						msg_pend_q <= msg_req; // RULE2
						tries_q    <= 4'h0;
						bus_err_q  <= 1'b0;
						cur_q      <= (sel_q != psw_pkg::PR_AUTO) ? sel_q :
							(nvdef_q != psw_pkg::PR_AUTO) ? nvdef_q :
							(std_q ? psw_pkg::PR_FIRST : psw_pkg::PR_CAN_LO); // RULE12
						st_q       <= psw_pkg::SR_INIT;
					end
				end
				psw_pkg::SR_INIT: begin
					init_req  <= 1'b1;
					try_proto <= cur_q;
					st_q      <= psw_pkg::SR_WAIT;
				end
				psw_pkg::SR_WAIT: begin
					if (init_ok) begin
						st_q       <= psw_pkg::SR_CONN;
						msg_go     <= msg_pend_q; // RULE2
						msg_pend_q <= 1'b0;
					end else if (init_fail) begin
						if (auto_q && tries_q < psw_pkg::PR_COUNT - 4'h1) begin
							tries_q <= tries_q + 4'h1; // RULE5
							cur_q   <= next_proto(cur_q, std_q);
							st_q    <= psw_pkg::SR_INIT;
						end else begin
							bus_err    <= 1'b1; // RULE8
							bus_err_q  <= 1'b1;
							msg_pend_q <= 1'b0;
							st_q       <= psw_pkg::SR_IDLE;
						end
					end
				end
				psw_pkg::SR_CONN: begin
					if (cmd_stb && (op == psw_pkg::OP_CLOSE || op == psw_pkg::OP_SETPROTO)) begin
						st_q <= psw_pkg::SR_IDLE;
					end else if (msg_req) begin
						msg_go <= 1'b1;
					end
				end
			endcase
		end
	end

	// Effective timeout: adaptive cap, then search floor
	always_comb begin
		tmo_eff = tmo_q;
		if (cfg_q[psw_pkg::CFG_ADAPT_BIT] && adapt_est != 8'h00 && adapt_est < tmo_q) begin
			tmo_eff = adapt_est; // RULE15
		end
		if (st_q != psw_pkg::SR_CONN && tmo_eff < psw_pkg::TMO_SEARCH_MIN) begin
			tmo_eff = psw_pkg::TMO_SEARCH_MIN; // RULE18
		end
		tmo_unit = (is_can(cur_q) && cfg_q[psw_pkg::CFG_CAN_TIMER_TIMES_FIVE_BIT]) ?
			CYC_W'(CAN5_CYCLES) : CYC_W'(STEP_CYCLES); // RULE14
	end

	psw_tick_timer #(.CYC_W(CYC_W)) u_tmo (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (req_sent || (rx_valid && tmo_run && cfg_q[psw_pkg::CFG_ADAPT_BIT])),
		.halt     (rx_valid && !cfg_q[psw_pkg::CFG_ADAPT_BIT]),
		.unit_cyc (tmo_unit),
		.units    (tmo_eff),
		.expired  (tmo_exp),
		.running  (tmo_run)
	);

	// No data only when nothing answered; wakeup replies are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			got_resp_q    <= 1'b0;
			no_data       <= 1'b0;
			nodata_seen_q <= 1'b0;
			wake_quiet_q  <= 1'b0;
			rx_accept     <= 1'b0;
		end else begin
			if (req_sent) begin
				got_resp_q <= 1'b0;
			end else if (rx_valid) begin
				got_resp_q <= 1'b1;
			end
			no_data <= tmo_exp && !got_resp_q && !wake_quiet_q; // RULE13
			if (tmo_exp && !got_resp_q && !wake_quiet_q) begin
				nodata_seen_q <= 1'b1;
			end else if (req_sent) begin
				nodata_seen_q <= 1'b0;
			end
			if (wake_req) begin
				wake_quiet_q <= 1'b1; // RULE19
			end else if (tmo_exp || msg_req) begin
				wake_quiet_q <= 1'b0;
			end
			rx_accept <= rx_valid && !wake_quiet_q && (!rxa_on_q || rx_addr == rxa_q ||
				cur_q == psw_pkg::PR_HDCAN || cfg_q[psw_pkg::CFG_EXTA_BIT]); // RULE10 RULE11 RULE19
		end
	end

	assign wake_ok = st_q == psw_pkg::SR_CONN && !wake_stop_q && (cur_q == psw_pkg::PR_SLOW_A ||
		cur_q == psw_pkg::PR_SLOW_B || cur_q == psw_pkg::PR_FAST_K); // RULE19

	psw_tick_timer #(.CYC_W(CYC_W)) u_wake (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (wake_ok && (!wake_run || msg_go)),
		.halt     (!wake_ok),
		.unit_cyc (CYC_W'(WAKE_CYCLES)),
		.units    (wake_arg_q),
		.expired  (wake_exp),
		.running  (wake_run)
	);

	// Wakeup strobe with additive checksum of the message bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_req  <= 1'b0;
			wake_csum <= 8'h00;
		end else begin
			wake_req  <= wake_exp && wake_ok; // RULE20 RULE22
			wake_csum <= wakmsg_q[31:24] + wakmsg_q[23:16] + wakmsg_q[15:8] + wakmsg_q[7:0]; // RULE22
		end
	end

	AST_SLOW_ERR: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		cmd_stb && op == psw_pkg::OP_SLOWINIT && sel_q == 4'h1 |=> cmd_err_q)
		else $error("slow init accepted on wrong protocol");
	AST_MSG_AFTER_INIT: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		st_q == psw_pkg::SR_WAIT && init_ok && msg_pend_q |=> msg_go && st_q == psw_pkg::SR_CONN)
		else $error("message not sent after initiation");
	AST_SP_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		cmd_stb && op == psw_pkg::OP_SETPROTO && form == psw_pkg::SPF_PLAIN && arg > 8'h00 && arg <= 8'h0c
		|=> nv_wr && nv_data[3:0] == $past(arg[3:0]) && !auto_q)
		else $error("set protocol did not store default");
	AST_SP0_NOWRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		cmd_stb && op == psw_pkg::OP_SETPROTO && form != psw_pkg::SPF_ZERO2 && arg == 8'h00 |=> !nv_wr && auto_q)
		else $error("zero protocol form wrote memory");
	AST_SP00_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		cmd_stb && op == psw_pkg::OP_SETPROTO && form == psw_pkg::SPF_ZERO2 |=> nv_wr && nv_data[3:0] == 4'h0)
		else $error("double zero did not write");
	AST_FIXED_FAIL: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		st_q == psw_pkg::SR_WAIT && init_fail && !init_ok && !auto_q |=> bus_err && st_q == psw_pkg::SR_IDLE)
		else $error("fixed protocol failure not reported");
	AST_RXA_FILTER: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		rx_valid && rxa_on_q && rx_addr != rxa_q && cur_q != 4'ha && !cfg_q[3] |=> !rx_accept)
		else $error("filtered address accepted");
	AST_TMO_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
		cmd_stb && op == psw_pkg::OP_TIMEOUT && arg == 8'h00 |=> tmo_q == $past(cfg_q[15:8]))
		else $error("zero timeout did not restore default");
	AST_SEARCH_MIN: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
		st_q != psw_pkg::SR_CONN |-> tmo_eff >= 8'h19)
		else $error("search timeout below minimum");
	AST_WAKE_PROTO: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
		wake_req |-> $past(cur_q) inside {4'h3, 4'h4, 4'h5} && !$past(wake_stop_q))
		else $error("wakeup on wrong protocol or while stopped");
	AST_BAD_CODE: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
		cmd_stb && op == psw_pkg::OP_SETPROTO && arg > 8'h0c |=> cmd_err_q && !nv_wr && $stable(sel_q))
		else $error("bad protocol code changed settings");
endmodule

// ---- psw_engine_model.sv ----
`timescale 1ns/1ns
// Engine stand-in: one result per attempt, after a set delay
module psw_engine_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       init_req,
	input  wire logic [3:0] try_proto,
	input  wire logic [3:0] good_proto,
	input  wire logic [7:0] delay,
	output logic            init_ok,
	output logic            init_fail
);
	logic [7:0] cnt_q;
	logic       busy_q;

	// Only the vehicle's own protocol initiates; a slow delay stretches each try
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q    <= 1'b0;
			cnt_q     <= 8'h00;
			init_ok   <= 1'b0;
			init_fail <= 1'b0;
		end else begin
			init_ok   <= 1'b0;
			init_fail <= 1'b0;
			if (init_req) begin
				busy_q <= 1'b1;
				cnt_q  <= delay;
			end else if (busy_q && cnt_q == 8'h00) begin
				busy_q    <= 1'b0;
				init_ok   <= (try_proto == good_proto);
				init_fail <= (try_proto != good_proto);
			end else if (busy_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
	logic        pclk, presetn, psel, penable, pwrite, msg_req, req_sent, rx_valid;
	logic        pready, pslverr, e, init_req, init_ok, init_fail, msg_go, wake_req;
	logic        no_data, bus_err, nv_wr, rx_accept;
	logic [7:0]  paddr, rx_addr, wake_csum, dly;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  try_proto;
	logic [4:0]  nv_data, nv_last;
	int          n_mismatch, checked, n_ini, n_go, n_berr, n_wake, n_nd, n_nv, n_acc, b;

	psw_protocol_ctrl #(.STEP_CYCLES(20), .CAN5_CYCLES(100), .WAKE_CYCLES(100)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .msg_req(msg_req),
		.init_ok(init_ok), .init_fail(init_fail), .req_sent(req_sent), .rx_valid(rx_valid),
		.rx_addr(rx_addr), .adapt_est(8'h00), .init_req(init_req), .try_proto(try_proto),
		.msg_go(msg_go), .wake_req(wake_req), .wake_csum(wake_csum), .no_data(no_data),
		.bus_err(bus_err), .nv_wr(nv_wr), .nv_data(nv_data), .rx_accept(rx_accept));
	psw_engine_model eng (.pclk(pclk), .presetn(presetn), .init_req(init_req), .try_proto(try_proto),
		.good_proto(4'h5), .delay(dly), .init_ok(init_ok), .init_fail(init_fail));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Tally one-cycle pulses; sampled at the edge so none is missed
	always @(posedge pclk) begin
		n_ini  <= n_ini + int'(init_req === 1'b1);
		n_go   <= n_go + int'(msg_go === 1'b1);
		n_berr <= n_berr + int'(bus_err === 1'b1);
		n_wake <= n_wake + int'(wake_req === 1'b1);
		n_nd   <= n_nd + int'(no_data === 1'b1);
		n_nv   <= n_nv + int'(nv_wr === 1'b1);
		n_acc  <= n_acc + int'(rx_accept === 1'b1);
		if (nv_wr === 1'b1)
			nv_last <= nv_data;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Setup then access, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r       = prdata;
		e       = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cmd(input logic [3:0] op, input logic [7:0] arg, input logic [1:0] form);
		apb(1'b1, psw_pkg::OFS_CMD, {18'h0, form, arg, op});
		repeat (2) @(posedge pclk);
	endtask

	// Command, then the error flag in status
	task automatic cmd_err(input logic [3:0] op, input logic [7:0] arg, input logic [1:0] form, input logic x);
		cmd(op, arg, form);
		apb(1'b0, psw_pkg::OFS_STATUS, 32'h0);
		chk(r[6], x);
	endtask

	task automatic pulse_sent();
		@(posedge pclk);
		req_sent <= 1'b1;
		@(posedge pclk);
		req_sent <= 1'b0;
	endtask

	task automatic rx(input logic [7:0] a);
		pulse_sent();
		rx_valid <= 1'b1;
		rx_addr  <= a;
		@(posedge pclk);
		rx_valid <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	// Ask for a message; wait, bounded, for sent or bus error
	task automatic go();
		int s;
		int n;
		s = n_go + n_berr;
		n = 0;
		@(posedge pclk);
		msg_req <= 1'b1;
		@(posedge pclk);
		msg_req <= 1'b0;
		while (n_go + n_berr == s && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		repeat (4) @(posedge pclk);
	endtask

	initial begin
		#600000;
		n_mismatch++;
		give_verdict();
	end

	initial begin
		presetn  = 1'b0;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 8'h00;
		pwdata   = 32'h0;
		msg_req  = 1'b0;
		req_sent = 1'b0;
		rx_valid = 1'b0;
		rx_addr  = 8'h00;
		dly      = 8'h02;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, psw_pkg::OFS_TIMING, 32'h0);
		chk(r, 32'h0000_9220);
		apb(1'b0, psw_pkg::OFS_CONFIG, 32'h0);
		chk(r, 32'h0000_2000);
		apb(1'b0, psw_pkg::OFS_WAKMSG, 32'h0);
		chk(r, psw_pkg::WAKMSG_RESET);
		chk(wake_csum, 8'hc4);
		apb(1'b0, 8'h20, 32'h0);
		chk({e, r[7:0]}, 9'h100);
		b = n_nv;
		cmd_err(4'h6, 8'h00, 2'h0, 1'b1);
		cmd_err(4'hf, 8'h00, 2'h0, 1'b1);
		cmd_err(4'h1, 8'h0d, 2'h0, 1'b1);
		cmd_err(4'h1, 8'h00, 2'h0, 1'b0);
		cmd_err(4'h1, 8'h00, 2'h2, 1'b0);
		cmd_err(4'h1, 8'h00, 2'h3, 1'b0);
		chk(n_nv - b, 0);
		cmd(4'h1, 8'h00, 2'h1);
		chk({n_nv - b, nv_last[3:0]}, 1 << 4);
		cmd(4'h1, 8'h05, 2'h3);
		chk(nv_last, 5'h15);
		cmd(4'h1, 8'h03, 2'h0);
		chk(nv_last, 5'h03);
		// Fixed protocol 3 against a vehicle that only speaks 5
		b = n_ini;
		cmd_err(4'h6, 8'h00, 2'h0, 1'b0);
		repeat (20) @(posedge pclk);
		go();
		chk(n_ini - b, 2);
		chk(n_go, 0);
		// Fast order from a zero default, slow answers
		cmd(4'h1, 8'h00, 2'h1);
		cmd(4'h3, 8'h01, 2'h0);
		b = n_ini;
		dly = 8'd20;
		go();
		chk(n_ini - b, 9);
		chk(n_go, 1);
		cmd(4'h8, 8'h00, 2'h0);
		apb(1'b1, psw_pkg::OFS_CONFIG, 32'h0000_2001);
		cmd(4'h7, 8'h00, 2'h0);
		cmd(4'h1, 8'h00, 2'h0);
		b = n_ini;
		dly = 8'h02;
		go();
		chk(n_ini - b, 5);
		chk(nv_last, 5'h15);
		b = n_wake;
		repeat (450) @(posedge pclk);
		chk((n_wake - b) inside {[3:5]}, 1);
		cmd(4'h3, 8'h00, 2'h0);
		b = n_wake;
		repeat (300) @(posedge pclk);
		chk(n_wake - b, 0);
		apb(1'b0, psw_pkg::OFS_TIMING, 32'h0);
		chk({r[31], r[15:8]}, 9'h101);
		cmd(4'h2, 8'h02, 2'h0);
		// A host message ends the quiet spell left by the last wakeup
		go();
		b = n_nd;
		pulse_sent();
		repeat (35) @(posedge pclk);
		chk(n_nd - b, 0);
		repeat (15) @(posedge pclk);
		chk(n_nd - b, 1);
		cmd(4'h2, 8'h00, 2'h0);
		apb(1'b0, psw_pkg::OFS_TIMING, 32'h0);
		chk(r[7:0], 8'h20);
		cmd(4'h4, 8'h33, 2'h0);
		b = n_acc;
		rx(8'h44);
		rx(8'h33);
		chk(n_acc - b, 1);
		cmd(4'h5, 8'h00, 2'h0);
		rx(8'h44);
		chk(n_acc - b, 2);
		give_verdict();
	end
endmodule
